// >>> design/bctm_base_counter.v
// Base counter of the capture timer: tick choice, TOP compare, waveform out
//
// What this block does
// - Counter ticks from the peripheral clock, the companion timer clock or rising edges of the event input.
// - Clock-source select picks one of the four sources; the chosen tick is registered before use.
// - Companion clock selected: counter advances in step with companion timer.
// - Zero is BOTTOM, all ones across sixteen bits is MAX.
// - TOP is the sequence's highest value; compare value in periodic mode.
// - Control accepts eight mode codes; only periodic and 8-bit PWM differ, the other six count alike.
// - After reset the block runs in periodic-interrupt mode.
// - Output enable drives the waveform onto the pin over the port value.
// - Enable bit starts the counter, advancing on each selected tick.
// - Live count value is readable at any time.
// - Reaching TOP raises the capture flag and emits a capture event.
// - Compare below the count outside PWM mode: count on to MAX and wrap to zero.
// - Periodic mode counts to the compare value, then restarts at BOTTOM.
`include "bctm_map.vh"
`timescale 1ns/1ps
module bctm_base_counter #(
    parameter CNT_W = `BCTM_CNT_W
) (
    // Clock and reset
    input  wire                   CLK,
    input  wire                   SRST,
    // Control
    input  wire                   ENABLE,
    input  wire [`BCTM_SEL_W-1:0] CLOCK_SOURCE_SELECT,
    input  wire [`BCTM_MODE_W-1:0] MODE,
    input  wire                   WAVEFORM_OUTPUT_ENABLE,
    input  wire [CNT_W-1:0]       COMPARE_CAPTURE_VALUE,
    input  wire                   CAPTURE_FLAG_CLEAR,
    // Tick sources
    input  wire                   COMPANION_TIMER_TICK,
    input  wire                   EVENT_IN,
    // Pin
    input  wire                   PORT_OUT_VALUE,
    output reg                    WAVEFORM_OUT_PIN,
    // Status
    output reg  [CNT_W-1:0]       COUNT_VALUE,
    output reg                    CAPTURE_INTERRUPT,
    output reg                    CAPTURE_EVENT,
    output reg  [`BCTM_MODE_W-1:0] MODE_ACTIVE
);
    wire             tick;
    reg  [CNT_W-1:0] cnt_next;
    reg              at_top;
    reg              wave_reg;
    reg              wave_next;
    reg              flag_next;

    // Mode localparams, one-hot form of the mode field
    localparam [7:0] ST_PERIOD = 8'h01;
    localparam [7:0] ST_PWM8   = 8'h80;
    reg  [7:0]       mode_oh;

    // One-hot decode shared by compare and waveform paths
    function [7:0] mode_onehot;
        input [`BCTM_MODE_W-1:0] m;
        begin
            mode_onehot = 8'h01 << m;
        end
    endfunction

    // Prescaler and source selection kept in its own leaf
    bctm_tick_sel #(
        .SEL_W (`BCTM_SEL_W)
    ) u_tick (
        .clk         (CLK),
        .srst        (SRST),
        .sel         (CLOCK_SOURCE_SELECT),
        .comp_tick   (COMPANION_TIMER_TICK),
        .event_level (EVENT_IN),
        .tick_reg    (tick)
    );

    // Compare and next count; PWM mode compares only the low byte
    always @* begin
        mode_oh  = mode_onehot(MODE_ACTIVE);
        cnt_next = COUNT_VALUE;
        at_top   = 1'b0;
        case (mode_oh)
            ST_PWM8: begin
                at_top = (COUNT_VALUE[7:0] == COMPARE_CAPTURE_VALUE[7:0]);
            end
            default: begin
                at_top = (COUNT_VALUE == COMPARE_CAPTURE_VALUE);
            end
        endcase
        if (ENABLE && tick) begin
            if (at_top && (mode_oh == ST_PERIOD || mode_oh == ST_PWM8)) begin
                cnt_next = `BCTM_BOTTOM;
            end else begin
                // Past a lowered TOP the add rolls MAX over to zero
                cnt_next = COUNT_VALUE + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Set wins over a clear arriving in the same cycle
    always @* begin
        flag_next = CAPTURE_INTERRUPT;
        if (CAPTURE_FLAG_CLEAR) begin
            flag_next = 1'b0;
        end
        if (ENABLE && tick && at_top) begin
            flag_next = 1'b1;
        end
    end

    // Waveform: high from BOTTOM, low at the duty value (compare high byte) in PWM mode, toggle at TOP otherwise
    always @* begin
        wave_next = wave_reg;
        if (ENABLE && tick) begin
            if (mode_oh == ST_PWM8) begin
                // Low once the count reaches the duty value, so high lasts that many ticks
                if (cnt_next[7:0] == COMPARE_CAPTURE_VALUE[15:8]) begin
                    wave_next = 1'b0;
                end else if (cnt_next[7:0] == 8'h00) begin
                    wave_next = 1'b1;
                end
            end else if (at_top) begin
                wave_next = ~wave_reg;
            end
        end
    end

    // Registered state and outputs
    always @(posedge CLK) begin
        if (SRST) begin
            COUNT_VALUE       <= `BCTM_RST_CNT;
            CAPTURE_INTERRUPT <= 1'b0;
            CAPTURE_EVENT     <= 1'b0;
            MODE_ACTIVE       <= `BCTM_RST_MODE;
            wave_reg          <= 1'b0;
            WAVEFORM_OUT_PIN  <= 1'b0;
        end else begin
            COUNT_VALUE       <= cnt_next;
            CAPTURE_INTERRUPT <= flag_next;
            CAPTURE_EVENT     <= ENABLE & tick & at_top;
            MODE_ACTIVE       <= MODE;
            wave_reg          <= wave_next;
            // Waveform overrides the port value while enabled
            WAVEFORM_OUT_PIN  <= WAVEFORM_OUTPUT_ENABLE ? wave_next : PORT_OUT_VALUE;
        end
    end
endmodule

// >>> design/bctm_map.vh
// Constants for the base capture timer counter
`ifndef BCTM_MAP_VH
`define BCTM_MAP_VH

// Counter width and landmark values
`define BCTM_CNT_W        16
`define BCTM_BOTTOM       16'h0000
`define BCTM_MAX          16'hFFFF

// Clock source select encodings
`define BCTM_SEL_W        2
`define BCTM_SEL_DIV1     2'h0
`define BCTM_SEL_DIV2     2'h1
`define BCTM_SEL_COMP     2'h2
`define BCTM_SEL_EVENT    2'h3

// Operating mode encodings (three bits, eight modes)
`define BCTM_MODE_W       3
`define BCTM_MODE_PERIOD  3'h0
`define BCTM_MODE_TMOUT   3'h1
`define BCTM_MODE_CAPEV   3'h2
`define BCTM_MODE_FREQ    3'h3
`define BCTM_MODE_PW      3'h4
`define BCTM_MODE_FRQPW   3'h5
`define BCTM_MODE_SHOT    3'h6
`define BCTM_MODE_PWM8    3'h7

// Reset values
`define BCTM_RST_CNT      16'h0000
`define BCTM_RST_CMP      16'h0000
`define BCTM_RST_MODE     3'h0
`define BCTM_RST_SEL      2'h0

// Prescaler divide for the halved peripheral clock
`define BCTM_PRE_DIV      2

`endif

// >>> design/bctm_tick_sel.v
// Tick selector: prescaler and clock source choice for the counter
`timescale 1ns/1ps
`include "bctm_map.vh"
module bctm_tick_sel #(
    parameter SEL_W = `BCTM_SEL_W
) (
    // Clock and reset
    input  wire             clk,
    input  wire             srst,
    // Source choice
    input  wire [SEL_W-1:0] sel,
    input  wire             comp_tick,
    input  wire             event_level,
    // Resulting tick
    output reg              tick_reg
);
    reg       pre_reg;
    reg       ev_q_reg;
    reg       tick_next;

    // Divide-by-two enable; a one-cycle pulse, not a derived clock
    always @(posedge clk) begin
        if (srst) begin
            pre_reg <= 1'b0;
            ev_q_reg <= 1'b0;
        end else begin
            pre_reg <= ~pre_reg;
            ev_q_reg <= event_level;
        end
    end

    // Exactly one source feeds the tick
    always @* begin
        case (sel)
            `BCTM_SEL_DIV1:  tick_next = 1'b1;
            `BCTM_SEL_DIV2:  tick_next = pre_reg;
            `BCTM_SEL_COMP:  tick_next = comp_tick;
            `BCTM_SEL_EVENT: tick_next = event_level & ~ev_q_reg;
            default:         tick_next = 1'b0;
        endcase
    end

    // Registered so the tick never glitches between sources
    always @(posedge clk) begin
        if (srst) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= tick_next;
        end
    end
endmodule

// >>> sim/bctm_base_counter_asserts.sv
// Port assertions for the base capture timer counter
`timescale 1ns/1ps
module bctm_base_counter_asserts #(parameter CNT_W = 16) (
    // Clock, reset and controls
    input wire             CLK,
    input wire             SRST,
    input wire             ENABLE,
    input wire [2:0]       MODE,
    input wire             WAVEFORM_OUTPUT_ENABLE,
    input wire [CNT_W-1:0] COMPARE_CAPTURE_VALUE,
    input wire             CAPTURE_FLAG_CLEAR,
    input wire             PORT_OUT_VALUE,
    // Outputs under watch
    input wire             WAVEFORM_OUT_PIN,
    input wire [CNT_W-1:0] COUNT_VALUE,
    input wire             CAPTURE_INTERRUPT,
    input wire             CAPTURE_EVENT,
    input wire [2:0]       MODE_ACTIVE
);
    // One clock domain, so one default for all checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    a_reset_clears: assert property ($past(SRST) |-> COUNT_VALUE == 0 && !CAPTURE_INTERRUPT)
        else $error("state not cleared by reset");
    a_mode_copy: assert property (MODE_ACTIVE == $past(MODE))
        else $error("mode copy wrong");
    a_hold_when_off: assert property (!ENABLE |=> $stable(COUNT_VALUE))
        else $error("count moved while disabled");
    a_step_by_one: assert property (COUNT_VALUE != $past(COUNT_VALUE) |->
        COUNT_VALUE == $past(COUNT_VALUE) + 1'b1 || COUNT_VALUE == 0) else $error("bad count step");
    a_event_at_top: assert property (CAPTURE_EVENT && $past(MODE_ACTIVE) == 3'h0 |->
        $past(COUNT_VALUE) == $past(COMPARE_CAPTURE_VALUE) && COUNT_VALUE == 0)
        else $error("event away from top");
    a_flag_on_event: assert property (CAPTURE_EVENT |-> CAPTURE_INTERRUPT)
        else $error("flag not set with event");
    a_flag_sticky: assert property (CAPTURE_INTERRUPT && !CAPTURE_FLAG_CLEAR |=> CAPTURE_INTERRUPT)
        else $error("flag dropped without clear");
    a_flag_clears: assert property (CAPTURE_FLAG_CLEAR |=> !CAPTURE_INTERRUPT || CAPTURE_EVENT)
        else $error("flag not cleared");
    a_port_passes: assert property (!WAVEFORM_OUTPUT_ENABLE |=> WAVEFORM_OUT_PIN == $past(PORT_OUT_VALUE))
        else $error("pin not port value");
    // Main scenarios reached
    cover property (CAPTURE_EVENT);
    cover property (COUNT_VALUE == 16'hFFFF ##1 COUNT_VALUE == 0);
    cover property (CAPTURE_FLAG_CLEAR && CAPTURE_INTERRUPT);
endmodule

// >>> sim/bctm_base_counter_bench.sv
// Self-checking bench for the base capture timer counter
`timescale 1ns/1ps
module bctm_base_counter_bench;
    reg         clk, srst, en, oe, clr, port;
    reg  [1:0]  sel;
    reg  [2:0]  mode;
    wire [2:0]  mode_act;
    reg  [15:0] cmp, a;
    reg  [16:0] cyc;
    wire        pin, irq, evt;
    wire [15:0] cnt;
    integer     num_errors, checks_done, n;
    // Companion ticks and event edges both repeat every four cycles
    bctm_base_counter i_bctm_base_counter (.CLK(clk), .SRST(srst), .ENABLE(en),
        .CLOCK_SOURCE_SELECT(sel), .MODE(mode), .WAVEFORM_OUTPUT_ENABLE(oe),
        .COMPARE_CAPTURE_VALUE(cmp), .CAPTURE_FLAG_CLEAR(clr),
        .COMPANION_TIMER_TICK(cyc[1:0] == 2'h0), .EVENT_IN(cyc[1]), .PORT_OUT_VALUE(port),
        .WAVEFORM_OUT_PIN(pin), .COUNT_VALUE(cnt), .CAPTURE_INTERRUPT(irq),
        .CAPTURE_EVENT(evt), .MODE_ACTIVE(mode_act));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task results;
        begin
            $display("errors %0d checks %0d", num_errors, checks_done);
            if (num_errors == 0 && checks_done > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // Ticks per 16 cycles; window is a multiple of every source period
    task t_rate(input [1:0] s, input [15:0] d);
        begin
            sel = s;
            repeat (8) @(negedge clk);
            a = cnt;
            repeat (16) @(negedge clk);
            chk(cnt - a, d);
        end
    endtask
    task t_hold;
        begin
            sel = 2'h0;
            en = 0;
            @(negedge clk);
            a = cnt;
            repeat (5) @(negedge clk);
            chk(cnt, a);
            en = 1;
        end
    endtask
    // Top lowered below count: climb to all ones, wrap, then top at 3
    task t_wrap;
        begin
            cmp = 16'h0003;
            while (cnt !== 16'hFFFF) @(negedge clk);
            chk(irq, 0);
            @(negedge clk);
            chk(cnt, 0);
            repeat (3) @(negedge clk);
            chk(cnt, 3);
            @(negedge clk);
            chk(cnt, 0);
            chk({14'h0000, evt, irq}, 16'h0003);
        end
    endtask
    // PWM: period of four ticks, high for two of them
    task t_pwm;
        begin
            mode = 3'h7;
            cmp = 16'h0203;
            repeat (4) @(negedge clk);
            chk(mode_act, 3'h7);
            n = 0;
            repeat (8) begin
                @(negedge clk);
                n = n + (pin === 1'b1);
            end
            chk(n, 4);
        end
    endtask
    task t_clear_pin;
        begin
            clr = 1;
            @(negedge clk);
            clr = 0;
            chk(irq, 0);
            port = 1;
            @(negedge clk);
            chk(pin, 1);
            port = 0;
            oe = 1;
            n = 0;
            repeat (8) begin
                a[0] = pin;
                @(negedge clk);
                n = n + (pin !== a[0]);
            end
            chk(n, 2);
        end
    endtask
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // Source stimulus and hang limit
    always @(negedge clk) begin
        cyc <= cyc + 1'b1;
        if (cyc == 80000) begin
            num_errors = num_errors + 1;
            results;
        end
    end
    initial begin
        {srst, en, oe, clr, port, sel, mode, cmp, cyc, num_errors, checks_done} = 0;
        srst = 1;
        cmp = 16'hFFFF;
        repeat (6) @(negedge clk);
        srst = 0;
        en = 1;
        chk(mode_act, 3'h0);
        t_rate(2'h0, 16);
        t_rate(2'h1, 8);
        t_rate(2'h2, 4);
        t_rate(2'h3, 4);
        t_hold;
        t_wrap;
        t_clear_pin;
        t_pwm;
        results;
    end
endmodule
bind bctm_base_counter bctm_base_counter_asserts #(.CNT_W(CNT_W)) i_bctm_base_counter_asserts (.*);
